// ### core/swrc_pkg.sv
// Constants, register map and types for the standby, wake and reset controller.
// Assumes one 20 MHz system clock; all counts below except OSC_WAIT_US (microseconds) are in cycles of it.
package swrc_pkg;

  // Clock and timing
  localparam int          CLK_HZ            = 20_000_000;
  localparam int          OSC_WAIT_US       = 100;
  localparam logic [11:0] OSC_WAIT_CYCLES   = 12'(OSC_WAIT_US * (CLK_HZ / 1_000_000));
  localparam int          RESTART_MIN       = 60;
  localparam int          RESTART_MAX       = 116;
  localparam logic [11:0] RESTART_CYCLES    = 12'h040;

  // Register bus
  localparam int          AVS_AW            = 4;
  localparam logic [3:0]  STATUS_OFS        = 4'h0;
  localparam logic [3:0]  CTRL_OFS          = 4'h4;
  localparam int          CTRL_WAIT_LSB     = 0;
  localparam int          CTRL_WAIT_W       = 12;
  localparam int          STAT_STATE_LSB    = 0;
  localparam int          STAT_FLAG_BIT     = 7;
  localparam int          STAT_FROM_SB_BIT  = 8;
  localparam int          STAT_KEYS_LSB     = 12;

  // Standby operand fields
  localparam int          OP_SENSE_BIT      = 3;
  localparam logic [2:0]  OP_STOP_ALL_A     = 3'h0;
  localparam logic [2:0]  OP_STOP_ALL_B     = 3'h3;
  localparam logic [2:0]  OP_STOP_K0        = 3'h6;
  localparam logic [2:0]  OP_HALT_TIMER     = 3'h5;

  // Synchroniser layout
  localparam int          SYNC_W            = 8;
  localparam logic [7:0]  SYNC_RESET_VAL    = 8'h00;

  typedef enum logic [6:0] {
    ST_RUN    = 7'h01,
    ST_DRAIN  = 7'h02,
    ST_STOP   = 7'h04,
    ST_WAIT   = 7'h08,
    ST_HALT   = 7'h10,
    ST_RHOLD  = 7'h20,
    ST_RCOUNT = 7'h40
  } swrc_state_e;

endpackage

// ### core/swrc_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the clock enable of the parent; held state is frozen while it is low.
`timescale 1ns/1ns
module swrc_sync #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic             I_CLK,
  input  wire logic             I_RESETN,
  input  wire logic             I_CE,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // First stage is read only by the second
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      stage1 <= RESET_VAL[WIDTH-1:0];
      o_sync <= RESET_VAL[WIDTH-1:0];
    end else if (I_CE) begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// ### core/swrc_core.sv
// Standby entry and exit, wake flag, reset pin and restart delay control.
// Assumes the processor issues one standby request pulse per standby
// instruction and stalls while O_CPU_HOLD is high; pins arrive asynchronously.
`timescale 1ns/1ns
module swrc_core
  import swrc_pkg::*;
(
  input  wire logic                        I_CLK,
  input  wire logic                        I_RESETN,
  input  wire logic                        I_CE,
  input  wire logic [swrc_pkg::AVS_AW-1:0] I_AVS_ADDRESS,
  input  wire logic                        I_AVS_READ,
  input  wire logic                        I_AVS_WRITE,
  input  wire logic [31:0]                 I_AVS_WRITEDATA,
  input  wire logic [3:0]                  I_AVS_BYTEENABLE,
  output logic      [31:0]                 O_AVS_READDATA,
  output logic                             O_AVS_WAITREQUEST,
  input  wire logic                        I_STANDBY_REQ,
  input  wire logic [3:0]                  I_STANDBY_OPERAND,
  input  wire logic                        I_FLAG_CLR,
  input  wire logic [3:0]                  I_KEY_INPUT_PINS,
  input  wire logic                        I_SENSE_INPUT_ZERO,
  input  wire logic                        I_SENSE_INPUT_ONE,
  input  wire logic [7:0]                  I_KEY_IO_DRIVE_HIGH,
  input  wire logic [8:0]                  I_TIMER_COUNT,
  input  wire logic                        I_TIMER_OUT_EN,
  input  wire logic                        I_RESET_PIN_N,
  input  wire logic                        I_POWER_ON_CLEAR,
  output logic                             O_CPU_HOLD,
  output logic                             O_RESUME,
  output logic                             O_RESTART_ZERO,
  output logic                             O_INT_RESET,
  output logic                             O_WAKE_FLAG,
  output logic                             O_OSC_RUN,
  output logic                             O_OSC_PINS_LOW,
  output logic                             O_TIMER_CLEAR,
  output logic                             O_RESET_PIN_O,
  output logic                             O_RESET_PIN_OE,
  output swrc_pkg::swrc_state_e            O_STATE
);

  import swrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic op_is_halt(input logic [3:0] op);
    op_is_halt = (op[2:0] == OP_HALT_TIMER);
  endfunction

  function automatic logic op_valid(input logic [3:0] op, input logic [7:0] kio);
    case (op[2:0])
      OP_STOP_ALL_A, OP_STOP_ALL_B: op_valid = &kio;
      OP_STOP_K0:                   op_valid = kio[0];
      OP_HALT_TIMER:                op_valid = 1'b1;
      default:                      op_valid = 1'b0;
    endcase
  endfunction

  function automatic logic wake_cond(input logic [3:0] op, input logic [3:0] keys,
                                     input logic sense, input logic tzero);
    logic sense_wake;
    sense_wake = op[OP_SENSE_BIT] & sense;
    if (op_is_halt(op)) begin
      wake_cond = tzero | sense_wake;
    end else begin
      wake_cond = (|keys) | sense_wake;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [SYNC_W-1:0] pins_s;
  logic [3:0]        keys_s;
  logic              sense_s;
  logic              rst_pin_n_s;
  logic              poc_s;

  swrc_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RESET_VAL)
  ) u_sync (
    .I_CLK    (I_CLK),
    .I_RESETN (I_RESETN),
    .I_CE     (I_CE),
    .i_async  ({I_POWER_ON_CLEAR, I_RESET_PIN_N, I_SENSE_INPUT_ONE,
                I_SENSE_INPUT_ZERO, I_KEY_INPUT_PINS}),
    .o_sync   (pins_s)
  );

  assign keys_s      = pins_s[3:0];
  assign sense_s     = pins_s[4] | pins_s[5];
  assign rst_pin_n_s = pins_s[6];
  assign poc_s       = pins_s[7];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  swrc_state_e st;
  swrc_state_e next_st;
  logic [3:0]  op;
  logic [3:0]  next_op;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic        flag;
  logic        next_flag;
  logic        from_sb;
  logic        next_from_sb;
  logic        next_resume;
  logic        next_rzero;
  logic        next_ireset;
  logic [11:0] wait_cfg;
  logic [11:0] wait_last;
  logic        rst_any;
  logic        timer_busy;
  logic        req_valid;
  logic        req_cond;
  logic        cur_cond;

  // While the pin is pulled low by power-on clear it also reads low
  assign rst_any    = !rst_pin_n_s || poc_s;
  assign timer_busy = (I_TIMER_COUNT != 9'h000) || I_TIMER_OUT_EN;
  assign req_valid  = op_valid(I_STANDBY_OPERAND, I_KEY_IO_DRIVE_HIGH);
  assign req_cond   = wake_cond(I_STANDBY_OPERAND, keys_s, sense_s,
                                I_TIMER_COUNT == 9'h000);
  assign cur_cond   = wake_cond(op, keys_s, sense_s, I_TIMER_COUNT == 9'h000);
  assign wait_last  = (wait_cfg == 12'h000) ? 12'h000 : wait_cfg - 12'h001;

  always_comb begin
    next_st      = st;
    next_op      = op;
    next_cnt     = cnt;
    next_flag    = I_FLAG_CLR ? 1'b0 : flag;
    next_from_sb = from_sb;
    next_resume  = 1'b0;
    next_rzero   = 1'b0;
    next_ireset  = 1'b0;
    if (rst_any) begin
      next_st  = ST_RHOLD;
      next_cnt = 12'h000;
      if (st != ST_RUN && st != ST_RHOLD && st != ST_RCOUNT) begin
        next_from_sb = 1'b1;
      end
    end else begin
      unique case (st)
        ST_RUN: begin
          if (I_STANDBY_REQ) begin
            if (!req_valid) begin
              next_ireset = 1'b1;
              next_rzero  = 1'b1;
              next_flag   = 1'b0;
            end else if (flag) begin
              next_flag   = req_cond;
              next_resume = 1'b1;
            end else if (req_cond) begin
              next_flag   = 1'b1;
              next_resume = 1'b1;
            end else begin
              next_op = I_STANDBY_OPERAND;
              if (op_is_halt(I_STANDBY_OPERAND)) begin
                next_st = ST_HALT;
              end else if (timer_busy) begin
                next_st = ST_DRAIN;
              end else begin
                next_st = ST_STOP;
              end
            end
          end
        end
        ST_DRAIN: begin
          if (!timer_busy) begin
            next_st = ST_STOP;
          end
        end
        ST_STOP: begin
          if (cur_cond) begin
            next_st  = ST_WAIT;
            next_cnt = 12'h000;
          end
        end
        ST_WAIT: begin
          if (cnt >= wait_last) begin
            if (cur_cond) begin
              next_st     = ST_RUN;
              next_flag   = 1'b1;
              next_resume = 1'b1;
            end else begin
              next_st = ST_STOP;
            end
          end else begin
            next_cnt = cnt + 12'h001;
          end
        end
        ST_HALT: begin
          if (cur_cond) begin
            next_st     = ST_RUN;
            next_flag   = 1'b1;
            next_resume = 1'b1;
          end
        end
        ST_RHOLD: begin
          next_st  = ST_RCOUNT;
          next_cnt = 12'h000;
        end
        ST_RCOUNT: begin
          if (cnt == RESTART_CYCLES - 12'h001) begin
            next_st      = ST_RUN;
            next_rzero   = 1'b1;
            next_flag    = from_sb;
            next_from_sb = 1'b0;
          end else begin
            next_cnt = cnt + 12'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      st      <= ST_RHOLD;
      op      <= 4'h0;
      cnt     <= 12'h000;
      flag    <= 1'b0;
      from_sb <= 1'b0;
    end else if (I_CE) begin
      st      <= next_st;
      op      <= next_op;
      cnt     <= next_cnt;
      flag    <= next_flag;
      from_sb <= next_from_sb;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_RESUME       <= 1'b0;
      O_RESTART_ZERO <= 1'b0;
      O_INT_RESET    <= 1'b0;
    end else if (I_CE) begin
      O_RESUME       <= next_resume;
      O_RESTART_ZERO <= next_rzero;
      O_INT_RESET    <= next_ireset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timer and pin controls

  // The system clock itself keeps running so that wake can be seen
  assign O_OSC_RUN      = !(st == ST_STOP || st == ST_RHOLD);
  assign O_OSC_PINS_LOW = (st == ST_STOP || st == ST_RHOLD);
  assign O_TIMER_CLEAR  = (st == ST_STOP) || (st == ST_WAIT);
  assign O_CPU_HOLD     = (st != ST_RUN);
  assign O_RESET_PIN_O  = 1'b0;
  assign O_RESET_PIN_OE = poc_s;
  assign O_WAKE_FLAG    = flag;
  assign O_STATE        = st;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle per access

  logic ack;

  assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !ack;

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      ack <= 1'b0;
    end else if (I_CE) begin
      ack <= (I_AVS_READ || I_AVS_WRITE) && !ack;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_CE && I_AVS_READ && !ack) begin
      O_AVS_READDATA <= 32'h0000_0000;
      if (I_AVS_ADDRESS == STATUS_OFS) begin
        O_AVS_READDATA[STAT_STATE_LSB +: 7]   <= st;
        O_AVS_READDATA[STAT_FLAG_BIT]         <= flag;
        O_AVS_READDATA[STAT_FROM_SB_BIT]      <= from_sb;
        O_AVS_READDATA[STAT_KEYS_LSB +: 4]    <= keys_s;
      end else if (I_AVS_ADDRESS == CTRL_OFS) begin
        O_AVS_READDATA[CTRL_WAIT_LSB +: CTRL_WAIT_W] <= wait_cfg;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      wait_cfg <= OSC_WAIT_CYCLES;
    end else if (I_CE && I_AVS_WRITE && ack && I_AVS_ADDRESS == CTRL_OFS) begin
      if (I_AVS_BYTEENABLE[0]) begin
        wait_cfg[7:0] <= I_AVS_WRITEDATA[7:0];
      end
      if (I_AVS_BYTEENABLE[1]) begin
        wait_cfg[11:8] <= I_AVS_WRITEDATA[11:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] rc_len;

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN || st != ST_RCOUNT) begin
      rc_len <= 8'h00;
    end else if (I_CE) begin
      rc_len <= rc_len + 8'h01;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  entry_flag_a: assert property (I_CE && st == ST_RUN && I_STANDBY_REQ && flag && !rst_any
    && req_valid |=> st == ST_RUN && O_RESUME && flag == $past(req_cond))
    else $error("standby entered with wake flag set");

  skip_cond_a: assert property (I_CE && st == ST_RUN && I_STANDBY_REQ && !flag && req_valid
    && req_cond && !rst_any |=> st == ST_RUN && flag) else $error("standby not skipped");

  bad_code_a: assert property (I_CE && st == ST_RUN && I_STANDBY_REQ && !req_valid
    && !rst_any |=> O_INT_RESET && O_RESTART_ZERO && !flag) else $error("no internal reset");

  exit_flag_a: assert property ((st == ST_HALT || st == ST_WAIT) ##1 st == ST_RUN
    |-> flag && O_RESUME) else $error("wake flag not set on wake");

  drain_hold_a: assert property (I_CE && st == ST_DRAIN && timer_busy && !rst_any
    |=> st == ST_DRAIN) else $error("STOP entered while timer busy");

  wait_back_a: assert property (I_CE && st == ST_WAIT && cnt >= wait_last && !cur_cond
    && !rst_any |=> st == ST_STOP) else $error("lost wake did not return to STOP");

  stop_osc_a: assert property (st == ST_STOP |-> !O_OSC_RUN && O_TIMER_CLEAR
    && O_CPU_HOLD) else $error("STOP without oscillator and timer halt");

  rst_hold_a: assert property (I_CE && rst_any |=> st == ST_RHOLD && O_OSC_PINS_LOW
    && !O_OSC_RUN) else $error("reset pin low did not hold reset");

  restart_len_a: assert property (st == ST_RCOUNT && I_CE && !rst_any && $past(st) != ST_RUN
    && next_st == ST_RUN |-> rc_len >= 8'h3B && rc_len <= 8'h73)
    else $error("restart delay out of range");

  poc_pin_a: assert property (I_CE && poc_s |=> st == ST_RHOLD &&
    $past(O_RESET_PIN_OE)) else $error("power-on clear not driving reset pin");

  halt_wake_c:  cover property (st == ST_HALT ##1 st == ST_RUN);
  stop_wake_c:  cover property (st == ST_WAIT ##1 st == ST_RUN);
  stop_back_c:  cover property (st == ST_WAIT ##1 st == ST_STOP);
  restart_c:    cover property (st == ST_RCOUNT ##1 O_RESTART_ZERO);

endmodule

// ### verification/swrc_far_model.sv
// Far-side model: key matrix, sense switches and external reset circuit.
// Assumes commands from the bench on the rising clock edge.
`timescale 1ns/1ns
module swrc_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_press,
  input  wire logic [5:0] i_mask,
  input  wire logic [7:0] i_len,
  input  wire logic       i_rst_hold,
  input  wire logic       i_dev_pull,
  output logic      [3:0] o_keys,
  output logic            o_sense_zero,
  output logic            o_sense_one,
  output logic            o_reset_pin_n
);
  logic [7:0] cnt = 8'h00;
  logic [5:0] lvl = 6'h00;
  // Press lasts i_len cycles, then lines fall to their pull-downs
  always_ff @(posedge i_clk) begin
    if (i_press) begin
      cnt <= i_len;
      lvl <= i_mask;
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else begin
      cnt <= 8'h00;
      lvl <= 6'h00;
    end
  end
  assign o_keys       = lvl[3:0];
  assign o_sense_zero = lvl[4];
  assign o_sense_one  = lvl[5];
  // Open-drain reset line: either party pulls it low
  assign o_reset_pin_n = ~(i_rst_hold | i_dev_pull);
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the standby, wake and reset controller.
// Assumes swrc_core and the far-side model on one 20 MHz clock.
`timescale 1ns/1ns
module tb_top;
  import swrc_pkg::*;
  logic        I_CLK = 0, I_RESETN = 0, req = 0, fclr = 0, press = 0;
  logic        rpin = 0, power_on_clear = 0, ten = 0, av_rd = 0, av_wr = 0, ce = 1, wr_s, seen;
  logic [3:0]  av_a = 4'h0, op = 4'h0, o4, keys;
  logic [31:0] av_d = 32'h0, rd, rd_s, q;
  logic [7:0]  kio = 8'hFF, plen = 8'h00, kv;
  logic [8:0]  tcnt = 9'h000;
  logic [5:0]  mask = 6'h00;
  logic        wreq, hold, resume, rz, ir, flag, osc, opl, tclr, po, poe, s0, s1, pin_n;
  swrc_state_e st;
  int          mismatches = 0, checks = 0, n, e;
  integer      seed;

  always #25 I_CLK = ~I_CLK;
  always @(negedge I_CLK) begin
    wr_s = wreq;
    rd_s = rd;
  end

  swrc_core u_swrc_core (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_CE(ce),
    .I_AVS_ADDRESS(av_a), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
    .I_AVS_WRITEDATA(av_d), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rd),
    .O_AVS_WAITREQUEST(wreq), .I_STANDBY_REQ(req), .I_STANDBY_OPERAND(op),
    .I_FLAG_CLR(fclr), .I_KEY_INPUT_PINS(keys), .I_SENSE_INPUT_ZERO(s0),
    .I_SENSE_INPUT_ONE(s1), .I_KEY_IO_DRIVE_HIGH(kio), .I_TIMER_COUNT(tcnt),
    .I_TIMER_OUT_EN(ten), .I_RESET_PIN_N(pin_n), .I_POWER_ON_CLEAR(power_on_clear),
    .O_CPU_HOLD(hold), .O_RESUME(resume), .O_RESTART_ZERO(rz), .O_INT_RESET(ir),
    .O_WAKE_FLAG(flag), .O_OSC_RUN(osc), .O_OSC_PINS_LOW(opl), .O_TIMER_CLEAR(tclr),
    .O_RESET_PIN_O(po), .O_RESET_PIN_OE(poe), .O_STATE(st));

  swrc_far_model u_swrc_far_model (.i_clk(I_CLK), .i_press(press), .i_mask(mask),
    .i_len(plen), .i_rst_hold(rpin), .i_dev_pull(poe & ~po), .o_keys(keys),
    .o_sense_zero(s0), .o_sense_one(s1), .o_reset_pin_n(pin_n));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    av_rd <= !w;
    av_wr <= w;
    av_a <= a;
    av_d <= d;
    do @(posedge I_CLK); while (wr_s !== 1'b0);
    q = rd_s;
    av_rd <= 0;
    av_wr <= 0;
  endtask

  // Status test op before standby; also sets key output drive
  task clr(input logic [7:0] k);
    @(posedge I_CLK);
    fclr <= 1;
    kio <= k;
    @(posedge I_CLK);
    fclr <= 0;
  endtask

  task sb(input logic [3:0] o);
    @(posedge I_CLK);
    req <= 1;
    op <= o;
    @(posedge I_CLK);
    req <= 0;
    @(negedge I_CLK);
  endtask

  task pr(input logic [5:0] m, input int l);
    @(posedge I_CLK);
    mask <= m;
    plen <= 8'(l);
    press <= 1;
    @(posedge I_CLK);
    press <= 0;
  endtask

  // 0: resume pulse, 1: restart pulse, 2: processor released
  task wt(input int sel, input int lim);
    n = 0;
    do begin
      @(negedge I_CLK);
      n++;
    end while (!(sel == 0 ? resume === 1'b1 : sel == 1 ? rz === 1'b1 : hold === 1'b0)
               && n < lim);
  endtask

  // 0: internal reset, 1: STOP, 2: HALT skipped as timer is already zero
  function automatic int expk(logic [3:0] o, logic [7:0] k);
    case (o[2:0])
      3'h0, 3'h3: return (k == 8'hFF) ? 1 : 0;
      3'h6:       return k[0] ? 1 : 0;
      3'h5:       return 2;
      default:    return 0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge I_CLK);
    mismatches++;
    stop_test;
  end

  initial begin
    seed = 32'hb8609422;
    repeat (20) @(posedge I_CLK);
    @(negedge I_CLK);
    chk("reset_hold", {st, opl, osc}, {ST_RHOLD, 2'b10});
    @(posedge I_CLK);
    I_RESETN <= 1;
    wt(1, 200);
    chk("restart_delay", n >= 60 && n <= 116, 1);
    bus(1, CTRL_OFS, 32'h8);
    bus(0, CTRL_OFS, 32'h0);
    chk("ctrl", q[11:0], 12'h008);
    bus(0, 4'h8, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(0, STATUS_OFS, 32'h0);
    chk("status", q[7:0], 8'h01);
    clr(8'hFF);
    sb(4'h0);
    chk("stop", {st, osc, opl, tclr, hold}, {ST_STOP, 4'b0111});
    pr(6'h10, 20);
    repeat (30) @(negedge I_CLK);
    chk("no_sense", st, ST_STOP);
    pr(6'h01, 3);
    seen = 0;
    repeat (30) begin
      @(negedge I_CLK);
      seen |= (st == ST_WAIT);
    end
    chk("back_to_stop", {seen, st}, {1'b1, ST_STOP});
    pr(6'h01, 20);
    wt(0, 60);
    chk("key_wake", {resume, flag, st}, {2'b11, ST_RUN});
    repeat (25) @(posedge I_CLK);
    sb(4'h0);
    chk("flag_false", {resume, flag, st}, {2'b10, ST_RUN});
    pr(6'h01, 30);
    repeat (4) @(posedge I_CLK);
    sb(4'h0);
    chk("already_true", {resume, flag, st}, {2'b11, ST_RUN});
    sb(4'h0);
    chk("flag_kept", {resume, flag, st}, {2'b11, ST_RUN});
    repeat (30) @(posedge I_CLK);
    clr(8'hFF);
    sb(4'h8);
    chk("sense_stop", st, ST_STOP);
    pr(6'h20, 20);
    wt(0, 60);
    chk("sense_wake", {resume, flag, st}, {2'b11, ST_RUN});
    repeat (25) @(posedge I_CLK);
    tcnt <= 9'h005;
    clr(8'h00);
    sb(4'h5);
    chk("halt", {st, osc, tclr}, {ST_HALT, 2'b10});
    repeat (5) @(negedge I_CLK);
    chk("halt_held", st, ST_HALT);
    // Clock enable low must freeze the wake even with the timer at zero
    @(posedge I_CLK);
    ce <= 0;
    tcnt <= 9'h000;
    repeat (5) @(negedge I_CLK);
    chk("halt_frozen", {st, resume}, {ST_HALT, 1'b0});
    @(posedge I_CLK);
    ce <= 1;
    wt(0, 10);
    chk("timer_wake", {resume, flag, st}, {2'b11, ST_RUN});
    @(posedge I_CLK);
    tcnt <= 9'h003;
    ten <= 1;
    clr(8'hFF);
    sb(4'h0);
    chk("drain", {st, osc}, {ST_DRAIN, 1'b1});
    @(posedge I_CLK);
    tcnt <= 9'h000;
    repeat (4) @(negedge I_CLK);
    chk("drain_en", st, ST_DRAIN);
    @(posedge I_CLK);
    ten <= 0;
    repeat (4) @(negedge I_CLK);
    chk("drain_done", st, ST_STOP);
    @(posedge I_CLK);
    rpin <= 1;
    repeat (5) @(negedge I_CLK);
    chk("pin_hold", {st, opl, osc, hold}, {ST_RHOLD, 3'b101});
    @(posedge I_CLK);
    rpin <= 0;
    wt(1, 200);
    chk("pin_delay", n >= 60 && n <= 116, 1);
    chk("pin_exit", {flag, st}, {1'b1, ST_RUN});
    @(posedge I_CLK);
    power_on_clear <= 1;
    repeat (5) @(negedge I_CLK);
    chk("poc_pin", {poe, po, st}, {2'b10, ST_RHOLD});
    @(posedge I_CLK);
    power_on_clear <= 0;
    wt(1, 200);
    chk("poc_restart", {rz, flag}, 2'b10);
    for (int i = 0; i < 12; i++) begin
      o4 = (i == 0) ? 4'h6 : (i == 1) ? 4'h3 : (i == 2) ? 4'hD : 4'($random(seed));
      kv = (i % 3 == 0) ? 8'hFF : (i % 3 == 1) ? 8'h01 : 8'($random(seed));
      e = expk(o4, kv);
      clr(kv);
      sb(o4);
      if (e == 0) begin
        chk("int_reset", {ir, rz}, 2'b11);
        wt(2, 200);
      end else if (e == 2) begin
        chk("halt_skip", {resume, flag, st}, {2'b11, ST_RUN});
      end else begin
        chk("key_stop", st, ST_STOP);
        pr(6'h08, 20);
        wt(0, 60);
        chk("rand_wake", {resume, flag}, 2'b11);
        repeat (25) @(posedge I_CLK);
      end
    end
    stop_test;
  end
endmodule
